/* design/serial_brg_pkg.sv */
// Purpose: Shared constants and carriers for the serial bit-rate block
// Assumes: APB with 32-bit data, byte offsets on word boundaries
// Notes:   Per-channel registers sit at a base plus channel times stride
package serial_brg_pkg;
   // -----------------------------------------------------------------
   // Sizes
   // -----------------------------------------------------------------
   localparam int NUM_CHAN = 2;
   localparam int ADDR_W   = 8;

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFF_DIV_BASE = 8'h00;   // Channel divisor
   localparam logic [7:0] OFF_FMT_BASE = 8'h04;   // Channel format
   localparam logic [7:0] OFF_CH_STEP  = 8'h08;   // Per-channel stride
   localparam logic [7:0] OFF_STOP     = 8'h10;
   localparam logic [7:0] OFF_PIN      = 8'h14;
   localparam logic [7:0] OFF_STAT     = 8'h18;

   // -----------------------------------------------------------------
   // Reset values and fixed bits
   // -----------------------------------------------------------------
   localparam logic [7:0] DIV_RST  = 8'hff;
   localparam logic [7:0] FMT_RST  = 8'h00;
   localparam logic [7:0] STOP_RST = 8'hff;
   localparam logic [7:0] PIN_RST  = 8'hc0;
   localparam logic [7:0] PIN_ONES = 8'hc0;      // Read as one, no write

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int FMT_SYNC_BIT  = 7;   // 1 = clocked synchronous mode
   localparam int FMT_PRE_LO    = 0;   // prescale_select_lo
   localparam int FMT_PRE_HI    = 1;   // prescale_select_hi
   localparam int STOP_CH1_BIT  = 6;   // chan1_standby_n
   localparam int PIN_RXINV_LSB = 0;   // chan1_rx_invert, +2 per channel
   localparam int PIN_TXINV_LSB = 1;   // chan1_tx_invert, +2 per channel
   localparam int PIN_TXSEL_LSB = 4;   // chan1_tx_pin_select, +1 per channel

   // -----------------------------------------------------------------
   // Prescaler codes and generator ratios
   // -----------------------------------------------------------------
   localparam logic [1:0] PRE_SYS    = 2'h0;
   localparam logic [1:0] PRE_SUB    = 2'h1;
   localparam logic [1:0] PRE_DIV16  = 2'h2;
   localparam logic [1:0] PRE_DIV64  = 2'h3;
   localparam logic [5:0] DIV16_LAST = 6'h0f;
   localparam logic [5:0] DIV64_LAST = 6'h3f;
   localparam logic [5:0] ASYNC_LAST = 6'h3f;   // 64 generator ticks per bit
   localparam logic [5:0] SYNC_LAST  = 6'h07;   // 8 generator ticks per bit
   localparam logic [1:0] SAMPLE_LAST = 2'h3;   // 4 ticks per 1/16 bit
   localparam int         SCLK_BIT   = 2;       // Half-bit phase in sync mode

   // -----------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic       sync_mode;
      logic [1:0] prescale;
      logic [7:0] divisor;
   } chan_cfg_s;

   typedef struct packed {
      logic sample_tick;
      logic bit_tick;
      logic sclk;
   } chan_tick_s;
endpackage : serial_brg_pkg

/* design/serial_bit_rate_and_standby_ctrl.sv */
// Purpose: Bit-rate generators, standby and pin control for two serial channels
// Assumes: All inputs synchronous to pclk; watch clock arrives as a pclk pulse
// Notes:   Register reads answer in the first access cycle
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps

// Contract
// - Eight-bit divisor register per channel, reset value all ones.
// - Chip standby, watch mode or channel standby force the divisor to all ones.
// - Divisor readable and writable at any time regardless of traffic.
// - Asynchronous bit lasts 64 * 4^n * (divisor+1) clocks.
// - Synchronous bit lasts 8 * 4^n * (divisor+1) clocks.
// - Prescale codes select system clock, subclock, clock/16, clock/64.
// - Subclock path uses watch clock halved, undivided in sub modes.
// - Clock stop register is eight bits read/write, resets to all ones.
// - Bit 6 low puts channel 1 into standby.
// - Bit 5 low puts channel 2 into standby.
// - A channel in standby holds all its registers at initial values.
// - Pin control register eight bits, resets to c0, top bits unwritable.
// - Separate receive and transmit inversion for each channel.
// - Bits 0 to 3 invert ch1 rx, ch1 tx, ch2 rx, ch2 tx.
// - Bits 4 and 5 route transmit pins to serial output; set before enabling.
// - Two top pin control bits read one and ignore writes.
module serial_bit_rate_and_standby_ctrl (
   // Clock and reset
   input  wire logic                                      pclk,
   input  wire logic                                      presetn,
   // APB slave
   input  wire logic                                      psel,
   input  wire logic                                      penable,
   input  wire logic                                      pwrite,
   input  wire logic [serial_brg_pkg::ADDR_W-1:0]         paddr,
   input  wire logic [31:0]                               pwdata,
   output logic      [31:0]                               prdata,
   output logic                                           pready,
   output logic                                           pslverr,
   // Chip power state
   input  wire logic                                      chip_standby,
   input  wire logic                                      watch_mode,
   input  wire logic                                      sub_mode,
   input  wire logic                                      wclk_tick,
   // Serial pins and channel data
   input  wire logic [serial_brg_pkg::NUM_CHAN-1:0]       rx_pin,
   input  wire logic [serial_brg_pkg::NUM_CHAN-1:0]       tx_data,
   input  wire logic [serial_brg_pkg::NUM_CHAN-1:0]       gpio_out,
   output logic      [serial_brg_pkg::NUM_CHAN-1:0]       rx_data,
   output logic      [serial_brg_pkg::NUM_CHAN-1:0]       tx_pin,
   output logic      [serial_brg_pkg::NUM_CHAN-1:0]       chan_run,
   output serial_brg_pkg::chan_tick_s [serial_brg_pkg::NUM_CHAN-1:0] chan_tick
);
   localparam int NC = serial_brg_pkg::NUM_CHAN;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // True when the address hits a channel register at the given base
   function automatic logic chan_hit(input logic [7:0] a, input logic [7:0] base,
                                     input int ch);
      logic [7:0] off;
      off = base + 8'(ch) * serial_brg_pkg::OFF_CH_STEP;
      return a == off;
   endfunction : chan_hit

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   serial_brg_pkg::chan_cfg_s          cfg_r    [NC];
   serial_brg_pkg::chan_cfg_s          cfg_nxt  [NC];
   logic [7:0]  stop_r,   stop_nxt;
   logic [7:0]  pin_r,    pin_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic        pready_r, pready_nxt;
   logic        perr_r,   perr_nxt;
   logic        wr_en;
   logic        setup;
   logic [NC-1:0] hold;

   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready_r & pwrite;

   // Channel standby comes from the low-active stop bits
   generate
      for (genvar c = 0; c < NC; c++) begin : g_hold
         // standby bit channel 1, standby bit channel 2
         assign hold[c] = ~stop_r[serial_brg_pkg::STOP_CH1_BIT - c];
      end
   endgenerate

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   // Read data and error are captured in the setup cycle
   always_comb begin
      logic hit;
      hit        = 1'b0;
      prdata_nxt = prdata_r;
      perr_nxt   = 1'b0;
      pready_nxt = setup;
      if (setup) begin
         prdata_nxt = 32'h0000_0000;
         for (int c = 0; c < NC; c++) begin
            if (chan_hit(paddr, serial_brg_pkg::OFF_DIV_BASE, c)) begin
               prdata_nxt[7:0] = cfg_r[c].divisor;
               hit = 1'b1;
            end
            if (chan_hit(paddr, serial_brg_pkg::OFF_FMT_BASE, c)) begin
               prdata_nxt[serial_brg_pkg::FMT_SYNC_BIT] = cfg_r[c].sync_mode;
               prdata_nxt[serial_brg_pkg::FMT_PRE_HI:serial_brg_pkg::FMT_PRE_LO] =
                  cfg_r[c].prescale;
               hit = 1'b1;
            end
         end
         if (paddr == serial_brg_pkg::OFF_STOP) begin
            prdata_nxt[7:0] = stop_r;
            hit = 1'b1;
         end
         if (paddr == serial_brg_pkg::OFF_PIN) begin
            prdata_nxt[7:0] = pin_r | serial_brg_pkg::PIN_ONES;
            hit = 1'b1;
         end
         if (paddr == serial_brg_pkg::OFF_STAT) begin
            prdata_nxt[4:0] = {chip_standby, watch_mode, sub_mode, ~hold};
            hit = 1'b1;
         end
         perr_nxt = ~hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         perr_r   <= 1'b0;
      end else begin
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         perr_r   <= perr_nxt;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = perr_r;

   // ----------------------------------------------------------------
   // Shared registers
   // ----------------------------------------------------------------
   // Clock stop and pin control writes
   always_comb begin
      stop_nxt = stop_r;
      pin_nxt  = pin_r;
      if (wr_en && paddr == serial_brg_pkg::OFF_STOP) begin
         stop_nxt = pwdata[7:0];
      end
      if (wr_en && paddr == serial_brg_pkg::OFF_PIN) begin
         pin_nxt = pwdata[7:0] | serial_brg_pkg::PIN_ONES;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_r <= serial_brg_pkg::STOP_RST;
         pin_r  <= serial_brg_pkg::PIN_RST;
      end else begin
         stop_r <= stop_nxt;
         pin_r  <= pin_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Prescaler and watch clock path
   // ----------------------------------------------------------------
   logic [5:0] pre_r,  pre_nxt;
   logic       half_r, half_nxt;
   logic       wsrc;

   // Free-running divider and watch clock halver
   always_comb begin
      pre_nxt  = pre_r + 6'h01;
      half_nxt = half_r ^ wclk_tick;
      // halved in active, full in sub modes
      wsrc     = wclk_tick & (sub_mode | half_r);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r  <= 6'h00;
         half_r <= 1'b0;
      end else begin
         pre_r  <= pre_nxt;
         half_r <= half_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Per-channel generator, config and pins
   // ----------------------------------------------------------------
   generate
      for (genvar c = 0; c < NC; c++) begin : g_chan
         logic [7:0] cnt_r,   cnt_nxt;
         logic [5:0] phase_r, phase_nxt;
         serial_brg_pkg::chan_tick_s tick_r, tick_nxt;
         logic       rx_r, rx_nxt;
         logic       tx_r, tx_nxt;
         logic       src;
         logic       brg;
         logic [5:0] last;

         // Configuration writes and forced values
         always_comb begin
            cfg_nxt[c] = cfg_r[c];
            if (wr_en && chan_hit(paddr, serial_brg_pkg::OFF_DIV_BASE, c)) begin
               cfg_nxt[c].divisor = pwdata[7:0];
            end
            if (wr_en && chan_hit(paddr, serial_brg_pkg::OFF_FMT_BASE, c)) begin
               cfg_nxt[c].sync_mode = pwdata[serial_brg_pkg::FMT_SYNC_BIT];
               cfg_nxt[c].prescale  =
                  pwdata[serial_brg_pkg::FMT_PRE_HI:serial_brg_pkg::FMT_PRE_LO];
            end
            if (chip_standby || watch_mode) begin
               cfg_nxt[c].divisor = serial_brg_pkg::DIV_RST;
            end
            if (hold[c]) begin
               cfg_nxt[c].divisor   = serial_brg_pkg::DIV_RST;
               cfg_nxt[c].sync_mode = serial_brg_pkg::FMT_RST[serial_brg_pkg::FMT_SYNC_BIT];
               cfg_nxt[c].prescale  = serial_brg_pkg::FMT_RST[1:0];
            end
         end

         // Source select, down-counter and bit phase
         always_comb begin
            case (cfg_r[c].prescale)
               serial_brg_pkg::PRE_SYS:   src = 1'b1;
               serial_brg_pkg::PRE_SUB:   src = wsrc;
               serial_brg_pkg::PRE_DIV16:
                  src = pre_r[3:0] == serial_brg_pkg::DIV16_LAST[3:0];
               serial_brg_pkg::PRE_DIV64: src = pre_r == serial_brg_pkg::DIV64_LAST;
               default:                   src = 1'b0;
            endcase
            last = cfg_r[c].sync_mode ? serial_brg_pkg::SYNC_LAST
                                      : serial_brg_pkg::ASYNC_LAST;
            brg     = src && cnt_r == 8'h00;
            cnt_nxt = cnt_r;
            if (src) begin
               cnt_nxt = brg ? cfg_r[c].divisor : cnt_r - 8'h01;
            end
            phase_nxt = phase_r;
            if (brg) begin
               phase_nxt = (phase_r >= last) ? 6'h00 : phase_r + 6'h01;
            end
            tick_nxt.sample_tick = brg && !cfg_r[c].sync_mode &&
                                   phase_r[1:0] == serial_brg_pkg::SAMPLE_LAST;
            tick_nxt.bit_tick    = brg && phase_r >= last;
            tick_nxt.sclk        = cfg_r[c].sync_mode & phase_r[serial_brg_pkg::SCLK_BIT];
            if (hold[c]) begin
               cnt_nxt   = 8'h00;
               phase_nxt = 6'h00;
               tick_nxt  = '0;
            end
         end

         // Pin inversion and transmit pin routing
         always_comb begin
            rx_nxt = rx_pin[c] ^ pin_r[serial_brg_pkg::PIN_RXINV_LSB + 2 * c];
            if (pin_r[serial_brg_pkg::PIN_TXSEL_LSB + c]) begin
               tx_nxt = tx_data[c] ^ pin_r[serial_brg_pkg::PIN_TXINV_LSB + 2 * c];
            end else begin
               tx_nxt = gpio_out[c];
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cfg_r[c].divisor   <= serial_brg_pkg::DIV_RST;
               cfg_r[c].sync_mode <= serial_brg_pkg::FMT_RST[serial_brg_pkg::FMT_SYNC_BIT];
               cfg_r[c].prescale  <= serial_brg_pkg::FMT_RST[1:0];
               cnt_r   <= 8'h00;
               phase_r <= 6'h00;
               tick_r  <= '0;
               rx_r    <= 1'b0;
               tx_r    <= 1'b0;
            end else begin
               cfg_r[c] <= cfg_nxt[c];
               cnt_r    <= cnt_nxt;
               phase_r  <= phase_nxt;
               tick_r   <= tick_nxt;
               rx_r     <= rx_nxt;
               tx_r     <= tx_nxt;
            end
         end

         // Channel outputs straight from flops
         assign chan_tick[c] = tick_r;
         assign rx_data[c]   = rx_r;
         assign tx_pin[c]    = tx_r;
         assign chan_run[c]  = stop_r[serial_brg_pkg::STOP_CH1_BIT - c];
      end
   endgenerate

endmodule : serial_bit_rate_and_standby_ctrl

/* tb/serial_brg_monitor.sv */
// Purpose: Port checker for the serial bit-rate block
// Assumes: APB answers one cycle after setup
// Notes:   Shadows follow pin control and clock stop writes
`timescale 1ns/1ps
module serial_brg_monitor (
   // Clock, reset and APB
   input wire logic                             pclk,
   input wire logic                             presetn,
   input wire logic                             psel,
   input wire logic                             penable,
   input wire logic                             pwrite,
   input wire logic [7:0]                       paddr,
   input wire logic [31:0]                      pwdata,
   input wire logic [31:0]                      prdata,
   input wire logic                             pready,
   // Power state and pins
   input wire logic                             chip_standby,
   input wire logic                             watch_mode,
   input wire logic [1:0]                       rx_pin,
   input wire logic [1:0]                       tx_data,
   input wire logic [1:0]                       gpio_out,
   input wire logic [1:0]                       rx_data,
   input wire logic [1:0]                       tx_pin,
   input wire logic [1:0]                       chan_run,
   input wire serial_brg_pkg::chan_tick_s [1:0] chan_tick
);
   logic [7:0] pin_r, pin_nxt, stop_r, stop_nxt;
   logic       wr_pin, wr_stop, pwr_hold;
   logic [1:0] tx_exp, rx_exp;
   // Shadow writes and expected pin levels
   always_comb begin
      wr_pin   = psel && penable && pready && pwrite && paddr == 8'h14;
      wr_stop  = psel && penable && pready && pwrite && paddr == 8'h10;
      pwr_hold = chip_standby | watch_mode;
      rx_exp   = rx_pin ^ {pin_r[2], pin_r[0]};
      pin_nxt  = wr_pin ? {2'h3, pwdata[5:0]} : pin_r;
      stop_nxt = wr_stop ? pwdata[7:0] : stop_r;
      for (int c = 0; c < 2; c++) begin
         tx_exp[c] = pin_r[4+c] ? tx_data[c] ^ pin_r[1+2*c] : gpio_out[c];
      end
   end
   // Shadow registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_r  <= 8'hc0;
         stop_r <= 8'hff;
      end else begin
         pin_r  <= pin_nxt;
         stop_r <= stop_nxt;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rd_answer; psel && !penable |=> pready; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("no answer after setup");
   property p_div_forced; $past(pwr_hold, 2) && $past(pwr_hold) && pready && !pwrite
      && (paddr == 8'h00 || paddr == 8'h08) |-> prdata[7:0] == 8'hff; endproperty
   a_div_forced: assert property (p_div_forced) else $error("divisor not forced");
   property p_pin_top; pready && !pwrite && paddr == 8'h14 |-> prdata[7:6] == 2'h3; endproperty
   a_pin_top: assert property (p_pin_top) else $error("pin top bits not one");
   property p_stop_ch1; wr_stop |-> ##[1:2] chan_run[0] == stop_r[6]; endproperty
   a_stop_ch1: assert property (p_stop_ch1) else $error("channel 1 run wrong");
   property p_stop_ch2; wr_stop |-> ##[1:2] chan_run[1] == stop_r[5]; endproperty
   a_stop_ch2: assert property (p_stop_ch2) else $error("channel 2 run wrong");
   property p_rx_inv; presetn |=> rx_data == $past(rx_exp); endproperty
   a_rx_inv: assert property (p_rx_inv) else $error("receive data wrong");
   property p_tx_pin; presetn |=> tx_pin == $past(tx_exp); endproperty
   a_tx_pin: assert property (p_tx_pin) else $error("transmit pin wrong");
   property p_quiet; !chan_run[0] && !$past(chan_run[0]) && !$past(chan_run[0], 2)
      |-> chan_tick[0] == 3'h0; endproperty
   a_quiet: assert property (p_quiet) else $error("ticks in standby");
   property p_sample_gap; chan_tick[0].sample_tick |=> !chan_tick[0].sample_tick [*3];
   endproperty
   a_sample_gap: assert property (p_sample_gap) else $error("sample ticks too close");
   c_bit: cover property (chan_tick[1].bit_tick);
   c_stop: cover property (wr_stop && !pwdata[6]);
   c_force: cover property (pwr_hold && pready);
endmodule : serial_brg_monitor

bind serial_bit_rate_and_standby_ctrl serial_brg_monitor i_mon (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .chip_standby(chip_standby),
   .watch_mode(watch_mode), .rx_pin(rx_pin), .tx_data(tx_data), .gpio_out(gpio_out),
   .rx_data(rx_data), .tx_pin(tx_pin), .chan_run(chan_run), .chan_tick(chan_tick));

/* tb/serial_peer_model.sv */
// Purpose: Remote serial peer on the receive pins
// Assumes: One pclk per peer step
// Notes:   Line pair takes a new value every cycle so one-cycle-stale data never matches
`timescale 1ns/1ps
module serial_peer_model (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Receive lines toward the block
   output logic      [1:0] rx_pin
);
   // Walk both lines through every pattern
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_pin <= 2'h0;
      end else begin
         rx_pin <= rx_pin + 2'h1;
      end
   end
endmodule : serial_peer_model

/* tb/serial_bit_rate_and_standby_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the serial bit-rate block
// Assumes: APB slave answers with no wait state
// Notes:   Watch clock pulse comes every fourth cycle
`timescale 1ns/1ps
module serial_bit_rate_and_standby_ctrl_tb_top;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, v;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h24ad29cc;
   logic        pready, pslverr, err, wclk_tick = 1'b0, sub_mode = 1'b0;
   logic        chip_standby = 1'b0, watch_mode = 1'b0;
   logic [1:0]  rx_pin, tx_data = 2'h0, gpio_out = 2'h0, rx_data, tx_pin, chan_run, rxs;
   logic [3:0]  wcnt = 4'h0;
   int          miscompares = 0, compares = 0;
   serial_brg_pkg::chan_tick_s [1:0] chan_tick;
   always #2.5 pclk = ~pclk;
   // Watch clock pulse once per four cycles
   always @(posedge pclk) begin
      wcnt      <= wcnt + 4'h1;
      wclk_tick <= wcnt[1:0] == 2'h3;
   end
   serial_bit_rate_and_standby_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .chip_standby(chip_standby),
      .watch_mode(watch_mode), .sub_mode(sub_mode), .wclk_tick(wclk_tick),
      .rx_pin(rx_pin), .tx_data(tx_data), .gpio_out(gpio_out), .rx_data(rx_data),
      .tx_pin(tx_pin), .chan_run(chan_run), .chan_tick(chan_tick));
   serial_peer_model i_peer (.pclk(pclk), .presetn(presetn), .rx_pin(rx_pin));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [1:0] exp_tx(input logic [7:0] p, input logic [1:0] d, g);
      for (int c = 0; c < 2; c++) exp_tx[c] = p[4+c] ? d[c] ^ p[1+2*c] : g[c];
   endfunction : exp_tx
   function automatic int exp_period(input logic s, sub, input logic [1:0] k, input int nv);
      int scale;
      scale = (k == 2'h0) ? 1 : (k == 2'h1) ? (sub ? 4 : 8) : (k == 2'h2) ? 16 : 64;
      return (s ? 8 : 64) * scale * (nv + 1);
   endfunction : exp_period
   task automatic print_verdict();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   task automatic timeout();
      miscompares++;
      print_verdict();
   endtask : timeout
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One APB transfer, then an idle edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) timeout();
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdchk
   // Cycles between bit ticks once the new setting has settled
   task automatic period(input int c, input int exp);
      int m;
      for (int k = 0; k < 4; k++) begin
         m = 0;
         do begin
            @(posedge pclk);
            m++;
         end while (chan_tick[c].bit_tick !== 1'b1 && m < 9000);
         if (m >= 9000) timeout();
      end
      check(m, exp);
   endtask : period
   initial begin
      logic [1:0] k;
      logic [7:0] nv;
      logic       s;
      int         c;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk(8'h00, 32'hff);
      rdchk(8'h0c, 32'h00);
      rdchk(8'h10, 32'hff);
      rdchk(8'h14, 32'hc0);
      apb(1'b0, 8'h1c, 32'h0);
      check({err, rd[30:0]}, 32'h80000000);
      $display("test reset values done");
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         apb(1'b1, {4'h0, i[0], 3'h0}, seed);
         rdchk({4'h0, i[0], 3'h0}, {24'h0, seed[7:0]});
      end
      apb(1'b1, 8'h14, 32'h00);
      rdchk(8'h14, 32'hc0);
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         v = {2'h3, seed[5:0]};
         apb(1'b1, 8'h14, {24'h0, v});
         tx_data  <= seed[9:8];
         gpio_out <= seed[11:10];
         @(posedge pclk);
         rxs = rx_pin;
         @(posedge pclk);
         check(rx_data, rxs ^ {v[2], v[0]});
         check(tx_pin, exp_tx(v, seed[9:8], seed[11:10]));
      end
      $display("test pin control done");
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         c = i % 2;
         k = i[1:0];
         s = k[1] | seed[0];
         nv = k[1] ? 8'h00 : {6'h0, seed[2:1]};
         sub_mode <= i[2];
         apb(1'b1, {4'h0, c[0], 3'h0}, {24'h0, nv});
         apb(1'b1, {4'h0, c[0], 3'h4}, {24'h0, s, 5'h0, k});
         period(c, exp_period(s, i[2], k, int'(nv)));
         check(chan_tick[c].sclk, s);
         rdchk({4'h0, c[0], 3'h4}, {24'h0, s, 5'h0, k});
      end
      sub_mode <= 1'b0;
      $display("test bit rate done");
      apb(1'b1, 8'h10, 32'hbf);
      apb(1'b1, 8'h00, 32'h12);
      rdchk(8'h00, 32'hff);
      check(chan_run, 32'h2);
      apb(1'b1, 8'h10, 32'hdf);
      check(chan_run, 32'h1);
      rdchk(8'h18, 32'h01);
      rdchk(8'h08, 32'hff);
      rdchk(8'h10, 32'hdf);
      apb(1'b1, 8'h10, 32'hff);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, 8'h08, 32'h5a);
         {watch_mode, chip_standby} <= i[0] ? 2'h2 : 2'h1;
         repeat (2) @(posedge pclk);
         rdchk(8'h08, 32'hff);
         rdchk(8'h18, i[0] ? 32'h0b : 32'h13);
         {watch_mode, chip_standby} <= 2'h0;
         @(posedge pclk);
      end
      $display("test standby done");
      print_verdict();
   end
endmodule : serial_bit_rate_and_standby_ctrl_tb_top
